// ==== rtl/tawu_defs.vh ====
// constants for the timer and watchdog unit: register map, fields, reset values
// assumes byte addressing on a 32-bit register bus, one aligned word per register
`ifndef TAWU_DEFS_VH
`define TAWU_DEFS_VH

`define TAWU_NUM_CTR      8
`define TAWU_DATA_W       32
`define TAWU_ADDR_W       8
`define TAWU_IDX_W        3
`define TAWU_THRESH_W     24

// byte offsets
`define TAWU_OFF_CTR_CTRL   8'h20
`define TAWU_OFF_INT_STAT   8'h24
`define TAWU_OFF_INT_MASK   8'h28
`define TAWU_OFF_WD_CTRL    8'h2C
`define TAWU_OFF_WD_PRESET  8'h30
`define TAWU_OFF_WD_THRESH  8'h34
`define TAWU_OFF_WD_SERVICE 8'h38
`define TAWU_OFF_WD_COUNT   8'h3C

// counter reload registers sit at 8'h00..8'h1C: top address bits zero
`define TAWU_CTR_SEL_MSB  7
`define TAWU_CTR_SEL_LSB  5
`define TAWU_CTR_IDX_MSB  4
`define TAWU_CTR_IDX_LSB  2
`define TAWU_CTR_SEL_VAL  3'h0

// counter control fields
`define TAWU_CC_EN_LSB    0
`define TAWU_CC_MODE_LSB  8
`define TAWU_CC_AUTO_LSB  16

// interrupt status / mask layout
`define TAWU_INT_W        10
`define TAWU_INT_WARN_BIT 8
`define TAWU_INT_EXP_BIT  9

// watchdog control fields
`define TAWU_WD_EN_BIT    0
`define TAWU_WD_NMI_BIT   1
`define TAWU_WD_RST_BIT   2
`define TAWU_WD_CTRL_W    3

// reset values and service key
`define TAWU_WD_PRESET_RST 32'hFFFFFFFF
`define TAWU_WD_THRESH_RST 24'hFFFFFF
`define TAWU_WD_KEY        32'h0000A5A5

// bus answers
`define TAWU_RESP_OKAY    2'h0
`define TAWU_RESP_SLVERR  2'h2

`endif

// ==== rtl/tawu_ctr.v ====
// one 32-bit down counter/timer with optional automatic reload
// assumes event_pulse is already synchronous to aclk and one cycle wide
`include "tawu_defs.vh"
`default_nettype none

module tawu_ctr
(
	// clock, reset and clock enable
	input  wire                     aclk,
	input  wire                     aresetn,
	input  wire                     ce,
	// control
	input  wire                     load_we,
	input  wire [`TAWU_DATA_W-1:0]  load_val,
	input  wire                     enable,
	input  wire                     count_events,
	input  wire                     auto_reload,
	input  wire                     event_pulse,
	// status
	output reg  [`TAWU_DATA_W-1:0]  count_reg,
	output reg                      tc_reg
);

	reg [`TAWU_DATA_W-1:0] reload_reg;
	wire                   tick;
	wire                   at_one;

	// timer mode ticks every core clock, counter mode on each event
	assign tick   = enable & (count_events ? event_pulse : 1'b1); // see RQ1 see RQ2
	assign at_one = (count_reg == {{(`TAWU_DATA_W-1){1'b0}}, 1'b1});

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			count_reg  <= {`TAWU_DATA_W{1'b0}};
			reload_reg <= {`TAWU_DATA_W{1'b0}};
			tc_reg     <= 1'b0;
		end
		else if (ce)
		begin
			tc_reg <= 1'b0;
			if (load_we)
			begin
				count_reg  <= load_val;
				reload_reg <= load_val;
			end
			else if (tick && count_reg != {`TAWU_DATA_W{1'b0}})
			begin
				if (at_one)
				begin
					tc_reg    <= 1'b1; // see RQ3
					count_reg <= auto_reload ? reload_reg : {`TAWU_DATA_W{1'b0}};
				end
				else
				begin
					count_reg <= count_reg - {{(`TAWU_DATA_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end

endmodule

`default_nettype wire

// ==== rtl/tawu_top.v ====
// timer and watchdog unit: eight counter/timers and a 32-bit watchdog,
// registers reached over an AXI4-Lite slave port
// assumes aclk is the core timing clock; event inputs come from pins
//
// Notes on behaviour
// RQ1 - eight independent 32-bit counter/timers, each set up as event counter or timer
// RQ2 - every counter/timer is timed from the core timing clock
// RQ3 - each counter/timer raises its own interrupt at terminal count
// RQ4 - 32-bit watchdog can be set up to give an NMI or a board reset
// RQ5 - enabled watchdog runs freely; software must service it regularly
// RQ6 - watchdog comes up disabled and drives neither output until enabled
// RQ7 - early-warning output rises when enabled count reaches the 24-bit threshold
// RQ8 - interrupt controller takes the early-warning output as an interrupt input
// RQ9 - expiry output rises when the enabled full 32-bit count expires
// RQ10 - board reset logic resets the board while the expiry output is high
// RQ11 - service reloads the watchdog count and drops the early warning
//
// Implementation choices: the address map and the AXI4-Lite register port.
`include "tawu_defs.vh"
`default_nettype none

module tawu_top
(
	// clock, reset, clock enable
	input  wire                        aclk,
	input  wire                        aresetn,
	input  wire                        ce,
	// axi4-lite write address
	input  wire [`TAWU_ADDR_W-1:0]     s_axi_awaddr,
	input  wire                        s_axi_awvalid,
	output wire                        s_axi_awready,
	// axi4-lite write data
	input  wire [`TAWU_DATA_W-1:0]     s_axi_wdata,
	input  wire [`TAWU_DATA_W/8-1:0]   s_axi_wstrb,
	input  wire                        s_axi_wvalid,
	output wire                        s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]                  s_axi_bresp,
	output reg                         s_axi_bvalid,
	input  wire                        s_axi_bready,
	// axi4-lite read address
	input  wire [`TAWU_ADDR_W-1:0]     s_axi_araddr,
	input  wire                        s_axi_arvalid,
	output wire                        s_axi_arready,
	// axi4-lite read data
	output reg  [`TAWU_DATA_W-1:0]     s_axi_rdata,
	output reg  [1:0]                  s_axi_rresp,
	output reg                         s_axi_rvalid,
	input  wire                        s_axi_rready,
	// counter event pins
	input  wire [`TAWU_NUM_CTR-1:0]    event_in,
	// toward interrupt controller and board reset logic
	output wire [`TAWU_NUM_CTR-1:0]    timer_irq,
	output reg                         watchdog_early_warning_out,
	output reg                         watchdog_expiry_out,
	output wire                        irq
);

	localparam CW = `TAWU_DATA_W;
	localparam NC = `TAWU_NUM_CTR;

	// true when the address selects one of the counter reload words
	function is_ctr;
		input [`TAWU_ADDR_W-1:0] a;
		begin
			is_ctr = (a[`TAWU_CTR_SEL_MSB:`TAWU_CTR_SEL_LSB] == `TAWU_CTR_SEL_VAL);
		end
	endfunction

	// merge new bytes into an old word under the byte strobes
	function [CW-1:0] merge;
		input [CW-1:0]   old_w;
		input [CW-1:0]   new_w;
		input [CW/8-1:0] strb;
		integer          k;
		begin
			merge = old_w;
			for (k = 0; k < CW/8; k = k + 1)
			begin
				if (strb[k])
					merge[k*8 +: 8] = new_w[k*8 +: 8];
			end
		end
	endfunction

	// bus state
	reg                      aw_full_reg;
	reg [`TAWU_ADDR_W-1:0]   aw_addr_reg;
	reg                      w_full_reg;
	reg [CW-1:0]             w_data_reg;
	reg [CW/8-1:0]           w_strb_reg;
	wire                     do_write;
	wire [`TAWU_IDX_W-1:0]   w_idx;
	wire [CW-1:0]            mask_word, clr_word, thr_word, wdc_word;

	// software registers
	reg [CW-1:0]             ctr_ctrl_reg;
	reg [`TAWU_INT_W-1:0]    int_stat_reg;
	reg [`TAWU_INT_W-1:0]    int_stat_next;
	reg [`TAWU_INT_W-1:0]    int_mask_reg;
	reg [`TAWU_WD_CTRL_W-1:0] wd_ctrl_reg;
	reg [CW-1:0]             wd_preset_reg;
	reg [`TAWU_THRESH_W-1:0] early_warning_threshold;
	reg [CW-1:0]             wd_count_reg;

	// event pin synchronisers
	reg [NC-1:0]             ev_meta_reg;
	reg [NC-1:0]             ev_sync_reg;
	reg [NC-1:0]             ev_last_reg;
	wire [NC-1:0]            ev_pulse;

	// counter bank
	wire [NC*CW-1:0]         ctr_count_bus;
	wire [NC-1:0]            ctr_tc;
	wire [NC-1:0]            ctr_load_we;
	wire [CW-1:0]            ctr_load_val;

	// watchdog
	wire                     wd_service;
	wire                     wd_warn_hit;
	wire                     wd_exp_hit;
	wire                     wd_warn_set;
	wire                     wd_exp_set;

	// read mux
	reg [CW-1:0]             rd_word;
	reg [1:0]                rd_resp;

	assign s_axi_awready = ce & ~aw_full_reg & ~s_axi_bvalid;
	assign s_axi_wready  = ce & ~w_full_reg & ~s_axi_bvalid;
	assign s_axi_arready = ce & ~s_axi_rvalid;
	assign do_write      = ce & aw_full_reg & w_full_reg & ~s_axi_bvalid;
	assign w_idx         = aw_addr_reg[`TAWU_CTR_IDX_MSB:`TAWU_CTR_IDX_LSB];
	assign mask_word = merge({{(CW-`TAWU_INT_W){1'b0}}, int_mask_reg}, w_data_reg, w_strb_reg);
	assign clr_word  = merge({CW{1'b0}}, w_data_reg, w_strb_reg);
	assign thr_word  = merge({{(CW-`TAWU_THRESH_W){1'b0}}, early_warning_threshold},
		w_data_reg, w_strb_reg);
	assign wdc_word  = merge({{(CW-`TAWU_WD_CTRL_W){1'b0}}, wd_ctrl_reg},
		w_data_reg, w_strb_reg) | {{(CW-1){1'b0}}, wd_ctrl_reg[`TAWU_WD_EN_BIT]}; // see RQ5

	// write channels are taken in either order, then performed together
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full_reg  <= 1'b0;
			aw_addr_reg  <= {`TAWU_ADDR_W{1'b0}};
			w_full_reg   <= 1'b0;
			w_data_reg   <= {CW{1'b0}};
			w_strb_reg   <= {(CW/8){1'b0}};
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `TAWU_RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_full_reg  <= 1'b0;
				w_full_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (is_ctr(aw_addr_reg) || aw_addr_reg == `TAWU_OFF_CTR_CTRL
					|| aw_addr_reg == `TAWU_OFF_INT_STAT || aw_addr_reg == `TAWU_OFF_INT_MASK
					|| aw_addr_reg == `TAWU_OFF_WD_CTRL || aw_addr_reg == `TAWU_OFF_WD_PRESET
					|| aw_addr_reg == `TAWU_OFF_WD_THRESH
					|| aw_addr_reg == `TAWU_OFF_WD_SERVICE)
					s_axi_bresp <= `TAWU_RESP_OKAY;
				else
					s_axi_bresp <= `TAWU_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// register writes
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctr_ctrl_reg            <= {CW{1'b0}};
			int_mask_reg            <= {`TAWU_INT_W{1'b0}};
			wd_ctrl_reg             <= {`TAWU_WD_CTRL_W{1'b0}}; // see RQ6
			wd_preset_reg           <= `TAWU_WD_PRESET_RST;
			early_warning_threshold <= `TAWU_WD_THRESH_RST;
		end
		else if (ce && do_write)
		begin
			if (aw_addr_reg == `TAWU_OFF_CTR_CTRL)
				ctr_ctrl_reg <= merge(ctr_ctrl_reg, w_data_reg, w_strb_reg); // see RQ1
			else if (aw_addr_reg == `TAWU_OFF_INT_MASK)
				int_mask_reg <= mask_word[`TAWU_INT_W-1:0];
			else if (aw_addr_reg == `TAWU_OFF_WD_CTRL)
				wd_ctrl_reg <= wdc_word[`TAWU_WD_CTRL_W-1:0]; // see RQ4
			else if (aw_addr_reg == `TAWU_OFF_WD_PRESET)
				wd_preset_reg <= merge(wd_preset_reg, w_data_reg, w_strb_reg);
			else if (aw_addr_reg == `TAWU_OFF_WD_THRESH)
				early_warning_threshold <= thr_word[`TAWU_THRESH_W-1:0];
		end
	end

	// event pins: two flops, then an edge detector on the second
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ev_meta_reg <= {NC{1'b0}};
			ev_sync_reg <= {NC{1'b0}};
			ev_last_reg <= {NC{1'b0}};
		end
		else if (ce)
		begin
			ev_meta_reg <= event_in;
			ev_sync_reg <= ev_meta_reg;
			ev_last_reg <= ev_sync_reg;
		end
	end

	assign ev_pulse     = ev_sync_reg & ~ev_last_reg;
	assign ctr_load_we  = (do_write && is_ctr(aw_addr_reg)) ?
		({{(NC-1){1'b0}}, 1'b1} << w_idx) : {NC{1'b0}};
	assign ctr_load_val = merge(ctr_count_bus[w_idx*CW +: CW], w_data_reg, w_strb_reg);

	genvar gi;
	generate
		for (gi = 0; gi < NC; gi = gi + 1)
		begin : g_ctr
			tawu_ctr u_ctr
			(
				.aclk         (aclk),
				.aresetn      (aresetn),
				.ce           (ce),
				.load_we      (ctr_load_we[gi]),
				.load_val     (ctr_load_val),
				.enable       (ctr_ctrl_reg[`TAWU_CC_EN_LSB + gi]),
				.count_events (ctr_ctrl_reg[`TAWU_CC_MODE_LSB + gi]),
				.auto_reload  (ctr_ctrl_reg[`TAWU_CC_AUTO_LSB + gi]),
				.event_pulse  (ev_pulse[gi]),
				.count_reg    (ctr_count_bus[gi*CW +: CW]),
				.tc_reg       (ctr_tc[gi])
			);
		end
	endgenerate

	// watchdog: free-running up count from zero, service by key write
	assign wd_service  = do_write && aw_addr_reg == `TAWU_OFF_WD_SERVICE
		&& clr_word == `TAWU_WD_KEY;
	assign wd_warn_hit = wd_ctrl_reg[`TAWU_WD_EN_BIT] & wd_ctrl_reg[`TAWU_WD_NMI_BIT]
		& (wd_count_reg == {{(CW-`TAWU_THRESH_W){1'b0}}, early_warning_threshold});
	assign wd_exp_hit  = wd_ctrl_reg[`TAWU_WD_EN_BIT] & wd_ctrl_reg[`TAWU_WD_RST_BIT]
		& (wd_count_reg == wd_preset_reg);
	assign wd_warn_set = ce & wd_warn_hit & ~wd_service & ~watchdog_early_warning_out;
	assign wd_exp_set  = ce & wd_exp_hit & ~wd_service & ~watchdog_expiry_out;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wd_count_reg               <= {CW{1'b0}};
			watchdog_early_warning_out <= 1'b0; // see RQ6
			watchdog_expiry_out        <= 1'b0;
		end
		else if (ce)
		begin
			if (wd_service)
			begin
				wd_count_reg               <= {CW{1'b0}}; // see RQ11
				watchdog_early_warning_out <= 1'b0;
			end
			else
			begin
				// count stops at the preset and holds there until a service
				if (wd_ctrl_reg[`TAWU_WD_EN_BIT] && wd_count_reg != wd_preset_reg)
					wd_count_reg <= wd_count_reg + {{(CW-1){1'b0}}, 1'b1}; // see RQ5
				if (wd_warn_hit)
					watchdog_early_warning_out <= 1'b1; // see RQ7
			end
			// expiry holds until the board reset it causes
			if (wd_exp_hit && !wd_service)
				watchdog_expiry_out <= 1'b1; // see RQ9
		end
	end

	// sticky interrupt status, write one to clear; a new event wins
	always @*
	begin
		int_stat_next = int_stat_reg;
		if (do_write && aw_addr_reg == `TAWU_OFF_INT_STAT)
			int_stat_next = int_stat_reg & ~clr_word[`TAWU_INT_W-1:0];
		int_stat_next = int_stat_next | {wd_exp_set, wd_warn_set, ctr_tc}; // see RQ3
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
			int_stat_reg <= {`TAWU_INT_W{1'b0}};
		else if (ce)
			int_stat_reg <= int_stat_next;
	end

	assign timer_irq = int_stat_reg[NC-1:0] & int_mask_reg[NC-1:0]; // see RQ3
	assign irq       = |(int_stat_reg & int_mask_reg);

	// read decode
	always @*
	begin
		rd_word = {CW{1'b0}};
		rd_resp = `TAWU_RESP_OKAY;
		if (is_ctr(s_axi_araddr))
			rd_word = ctr_count_bus[s_axi_araddr[`TAWU_CTR_IDX_MSB:`TAWU_CTR_IDX_LSB]*CW +: CW];
		else if (s_axi_araddr == `TAWU_OFF_CTR_CTRL)
			rd_word = ctr_ctrl_reg;
		else if (s_axi_araddr == `TAWU_OFF_INT_STAT)
			rd_word = {{(CW-`TAWU_INT_W){1'b0}}, int_stat_reg};
		else if (s_axi_araddr == `TAWU_OFF_INT_MASK)
			rd_word = {{(CW-`TAWU_INT_W){1'b0}}, int_mask_reg};
		else if (s_axi_araddr == `TAWU_OFF_WD_CTRL)
			rd_word = {{(CW-`TAWU_WD_CTRL_W){1'b0}}, wd_ctrl_reg};
		else if (s_axi_araddr == `TAWU_OFF_WD_PRESET)
			rd_word = wd_preset_reg;
		else if (s_axi_araddr == `TAWU_OFF_WD_THRESH)
			rd_word = {{(CW-`TAWU_THRESH_W){1'b0}}, early_warning_threshold};
		else if (s_axi_araddr == `TAWU_OFF_WD_SERVICE)
			rd_word = {CW{1'b0}};
		else if (s_axi_araddr == `TAWU_OFF_WD_COUNT)
			rd_word = wd_count_reg;
		else
			rd_resp = `TAWU_RESP_SLVERR;
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= {CW{1'b0}};
			s_axi_rresp  <= `TAWU_RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_resp;
			end
			else if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

// ==== verification/tawu_props.sv ====
// checker for the timer and watchdog unit, bound to its top module
// assumes one clock domain with a synchronous active-low reset
`include "tawu_defs.vh"
`default_nettype none
module tawu_props
(
	// clock, reset, enable
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        ce,
	// write channels
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	// read channels
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// pins and far side
	input wire logic [7:0]  event_in,
	input wire logic [7:0]  timer_irq,
	input wire logic        watchdog_early_warning_out,
	input wire logic        watchdog_expiry_out,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic wd_armed_reg;
	// remembers that the watchdog control register was addressed
	always_ff @(posedge aclk)
		if (!aresetn)
			wd_armed_reg <= 1'h0;
		else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == `TAWU_OFF_WD_CTRL)
			wd_armed_reg <= 1'h1;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_rst_quiet;
		disable iff (1'h0) !aresetn |=> !watchdog_early_warning_out && !watchdog_expiry_out
			&& !irq && timer_irq == 8'h00;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not quiet after reset");
	property p_arm_first;
		$rose(watchdog_early_warning_out) || $rose(watchdog_expiry_out) |-> wd_armed_reg;
	endproperty
	a_arm_first: assert property (p_arm_first) else $error("watchdog output before enable");
	property p_exp_hold;
		watchdog_expiry_out |=> watchdog_expiry_out;
	endproperty
	a_exp_hold: assert property (p_exp_hold) else $error("expiry dropped without reset");
	property p_warn_drop;
		$past(aresetn) && $fell(watchdog_early_warning_out) |-> $rose(s_axi_bvalid);
	endproperty
	a_warn_drop: assert property (p_warn_drop) else $error("warning fell without a write");
	property p_irq_or;
		timer_irq != 8'h00 |-> irq;
	endproperty
	a_irq_or: assert property (p_irq_or) else $error("counter interrupt missing on irq");
	property p_wr_lat;
		s_wr_taken ##1 ce |=> s_axi_bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write response late");
	property p_rd_lat;
		s_rd_taken |=> s_axi_rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read data late");
	property p_refuse;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_refuse: assert property (p_refuse) else $error("write taken while response pending");
	property p_ce_ready;
		!ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready;
	endproperty
	a_ce_ready: assert property (p_ce_ready) else $error("ready while clock enable low");
	property p_slverr;
		s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h3C |=>
			s_axi_rresp == `TAWU_RESP_SLVERR && s_axi_rdata == 32'h00000000;
	endproperty
	a_slverr: assert property (p_slverr) else $error("unmapped read not refused");
endmodule
`default_nettype wire

// ==== verification/tawu_partner.sv ====
// far-side model: interrupt controller inputs and board reset logic
// assumes the unit's outputs are synchronous to aclk
`default_nettype none
module tawu_partner
#(
	parameter int RST_HOLD = 4
)
(
	// clock, interrupt acknowledge and the unit's outputs
	input wire logic       aclk,
	input wire logic       int_ack,
	input wire logic [7:0] timer_irq,
	input wire logic       watchdog_early_warning_out,
	input wire logic       watchdog_expiry_out,
	// seen interrupts and board reset
	output logic [8:0]     int_seen,
	output logic           board_rst
);
	timeunit 1ns;
	timeprecision 1ps;
	int hold = 0;
	always @(posedge aclk)
	begin
		if (watchdog_expiry_out)
			hold <= RST_HOLD;
		else if (hold != 0)
			hold <= hold - 1;
		int_seen <= int_ack ? 9'h000 : int_seen | {watchdog_early_warning_out, timer_irq};
	end
	assign board_rst = hold != 0;
endmodule
`default_nettype wire

// ==== verification/tawu_top_tb.sv ====
// self-checking bench for the timer and watchdog unit with its far-side model
// assumes design files, checker and partner are compiled before this file
`include "tawu_defs.vh"
`default_nettype none
module tawu_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LIMIT = 5000;
	logic        aclk = 1'h0, rstn_reg = 1'h0, ce = 1'h1, int_ack = 1'h1;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, event_in = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
	logic        s_axi_bready = 1'h1, s_axi_rready = 1'h1;
	wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic   watchdog_early_warning_out, watchdog_expiry_out, irq, board_rst, aresetn;
	wire logic [1:0]  s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [7:0]  timer_irq;
	wire logic [8:0]  int_seen;
	wire logic [33:0] outs = {23'h0, timer_irq, watchdog_early_warning_out, watchdog_expiry_out, irq};
	logic [15:0] lfsr = 16'h001C;
	logic [31:0] rd_data;
	logic [1:0]  rd_resp, wr_resp;
	logic [7:0]  ld [8];
	int fail_count = 0, compares = 0, cyc = 0, n;
	// the board reset from the far side also resets the unit
	assign aresetn = rstn_reg && !board_rst;
	tawu_top u_dut (.*);
	tawu_partner u_far (.*);
	always #2.5 aclk = ~aclk;
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [31:0] thr_field(input logic [31:0] d);
		return {8'h00, d[23:0]};
	endfunction
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end
		while (!s_axi_bvalid);
		wr_resp = s_axi_bresp;
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end
		while (!s_axi_rvalid);
		rd_data = s_axi_rdata;
		rd_resp = s_axi_rresp;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk({rd_resp, rd_data}, {`TAWU_RESP_OKAY, e});
	endtask
	task automatic pulse;
		event_in <= 8'h01;
		repeat (4) @(posedge aclk);
		event_in <= 8'h00;
		repeat (8) @(posedge aclk);
	endtask
	task automatic report_and_stop;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			fail_count++;
			report_and_stop;
		end
	end
	initial
	begin
		repeat (4) @(posedge aclk);
		rstn_reg <= 1'h1;
		ce <= 1'h0;
		repeat (3) @(posedge aclk);
		ce <= 1'h1;
		int_ack <= 1'h0;
		chk(outs, 34'h0);
		rd_chk(`TAWU_OFF_WD_PRESET, `TAWU_WD_PRESET_RST);
		rd_chk(`TAWU_OFF_WD_THRESH, {8'h00, `TAWU_WD_THRESH_RST});
		rd_chk(`TAWU_OFF_WD_CTRL, 32'h0);
		rd_chk(`TAWU_OFF_WD_COUNT, 32'h0);
		// one byte lane only: the other threshold bytes keep their reset value
		s_axi_wstrb <= 4'h2;
		wr(`TAWU_OFF_WD_THRESH, 32'hFFFF00FF);
		s_axi_wstrb <= 4'hF;
		rd_chk(`TAWU_OFF_WD_THRESH, 32'h00FF00FF);
		lfsr = lfsr_next(lfsr);
		rd(8'h40 | {lfsr[7:2], 2'h0});
		chk({rd_resp, rd_data}, {`TAWU_RESP_SLVERR, 32'h0});
		wr(8'hFC, 32'h1);
		chk({32'h0, wr_resp}, {32'h0, `TAWU_RESP_SLVERR});
		// all eight as timers, counter 6 reloading, counter 7 at the smallest count
		wr(`TAWU_OFF_INT_MASK, 32'h3FF);
		for (int i = 0; i < 8; i++)
		begin
			lfsr = lfsr_next(lfsr);
			ld[i] = (i == 7) ? 8'h01 : {3'h0, lfsr[4:0]} + 8'h02;
			wr(8'(4 * i), {24'h0, ld[i]});
		end
		wr(`TAWU_OFF_CTR_CTRL, 32'h004000FF);
		repeat (40) @(posedge aclk);
		chk(outs, {23'h0, 8'hFF, 3'h1});
		rd_chk(`TAWU_OFF_INT_STAT, 32'hFF);
		for (int i = 0; i < 8; i++)
			if (i != 6)
				rd_chk(8'(4 * i), 32'h0);
		wr(`TAWU_OFF_INT_STAT, 32'hFF);
		repeat (40) @(posedge aclk);
		rd_chk(`TAWU_OFF_INT_STAT, 32'h40);
		// counter 0 as event counter, interrupt masked first
		wr(`TAWU_OFF_CTR_CTRL, 32'h100);
		wr(8'h00, 32'h2);
		wr(`TAWU_OFF_INT_MASK, 32'h0);
		wr(`TAWU_OFF_INT_STAT, 32'h3FF);
		wr(`TAWU_OFF_CTR_CTRL, 32'h101);
		pulse;
		rd_chk(8'h00, 32'h1);
		pulse;
		rd_chk(`TAWU_OFF_INT_STAT, 32'h1);
		chk(outs, 34'h0);
		wr(`TAWU_OFF_INT_MASK, 32'h1);
		chk(outs, {23'h0, 8'h01, 3'h1});
		wr(`TAWU_OFF_INT_STAT, 32'h1);
		chk(outs, 34'h0);
		// watchdog: warning, service, sticky enable, expiry
		wr(`TAWU_OFF_INT_MASK, 32'h100);
		lfsr = lfsr_next(lfsr);
		wr(`TAWU_OFF_WD_THRESH, {lfsr[15:8], 24'h000014});
		rd_chk(`TAWU_OFF_WD_THRESH, thr_field({lfsr[15:8], 24'h000014}));
		wr(`TAWU_OFF_WD_PRESET, 32'h0000003C);
		wr(`TAWU_OFF_WD_CTRL, 32'h7);
		repeat (16) @(posedge aclk);
		chk(outs, 34'h0);
		repeat (8) @(posedge aclk);
		chk({31'h0, outs[2], outs[0], int_seen[8]}, 34'h7);
		wr(`TAWU_OFF_WD_SERVICE, 32'h00001234);
		chk({33'h0, outs[2]}, 34'h1);
		wr(`TAWU_OFF_WD_CTRL, 32'h6);
		rd_chk(`TAWU_OFF_WD_CTRL, 32'h7);
		wr(`TAWU_OFF_WD_SERVICE, `TAWU_WD_KEY);
		chk({33'h0, outs[2]}, 34'h0);
		rd(`TAWU_OFF_WD_COUNT);
		chk({33'h0, rd_data < 32'h8}, 34'h1);
		repeat (4)
		begin
			repeat (30) @(posedge aclk);
			wr(`TAWU_OFF_WD_SERVICE, `TAWU_WD_KEY);
			chk({33'h0, outs[1]}, 34'h0);
		end
		n = 0;
		while (!watchdog_expiry_out && n < 200)
		begin
			@(posedge aclk);
			n++;
		end
		chk({33'h0, n >= 55 && n <= 65}, 34'h1);
		repeat (12) @(posedge aclk);
		chk(outs, 34'h0);
		rd_chk(`TAWU_OFF_WD_PRESET, `TAWU_WD_PRESET_RST);
		rd_chk(`TAWU_OFF_WD_CTRL, 32'h0);
		// enabled with warning and expiry both deselected: no output, no status
		wr(`TAWU_OFF_WD_THRESH, 32'h4);
		wr(`TAWU_OFF_WD_PRESET, 32'h8);
		wr(`TAWU_OFF_WD_CTRL, 32'h1);
		repeat (20) @(posedge aclk);
		chk(outs, 34'h0);
		rd_chk(`TAWU_OFF_INT_STAT, 32'h0);
		rd_chk(`TAWU_OFF_WD_COUNT, 32'h8);
		report_and_stop;
	end
endmodule
bind tawu_top tawu_props u_props (.*);
`default_nettype wire
